// ---- hdl/tsc_host_ctrl.sv ----
`include "tsc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tsc_host_ctrl
    import tsc_pkg::*;
#(
    parameter int unsigned POR_CYCLES = `TSC_POR_CYCLES
) (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  wire logic          hard_reset_in_n,
    input  wire logic          spi_cs_n,
    input  wire logic          spi_sclk,
    input  wire logic          spi_mosi,
    output logic               spi_miso,
    output logic               spi_miso_oe,
    output logic               interrupt_out_n,
    output logic               interrupt_out_n_oe,
    input  wire logic          pen_touch,
    input  wire logic          aux_sync,
    input  wire logic          adc_done,
    input  wire logic [11:0]   adc_result,
    output tsc_adc_req_s       adc_req,
    output tsc_cfg_s           cfg_out
);
    // both reset sources act at once, without the clock
    logic arst_n;
    assign arst_n = reset_n & hard_reset_in_n;

    // ---------------- control and serial state ----------------
    logic [16:0]  por_cnt_q, por_cnt_d;   // power-up counter
    logic         por_done_q, por_done_d; // power-up complete
    logic         sclk_q, sclk_d;         // last serial clock level
    logic         pen_q, pen_d;           // last pen level
    logic         aux_q, aux_d;           // last aux level
    logic [5:0]   bit_cnt_q, bit_cnt_d;   // bits taken this frame
    logic [7:0]   rx_q, rx_d;             // receive shift register
    logic [7:0]   cmd_q, cmd_d;           // command byte of frame
    logic [15:0]  tx_q, tx_d;             // transmit shift register
    logic         oe_q, oe_d;             // serial output enable
    tsc_cfg_s     cfg_q, cfg_d;           // host configuration
    logic         pen_flag_q, pen_flag_d; // pen event flag
    logic         data_rdy_q, data_rdy_d; // new channel data flag
    logic         irq_oe_q, irq_oe_d;     // interrupt pin pulled low
    logic         swrst_q, swrst_d;       // software reset pulse
    logic         conv_cmd_q, conv_cmd_d; // manual conversion request

    // ---------------- acquisition state ----------------
    typedef enum {ACQ_IDLE, ACQ_START, ACQ_WAIT} tsc_acq_state_e;
    tsc_acq_state_e acq_q, acq_d;         // sequencer state
    logic [2:0]   chan_q, chan_d;         // channel in progress
    logic         seq_done;               // sequence finished now
    tsc_adc_req_s req_q, req_d;           // converter request
    logic [11:0]  res_q [`TSC_CH_COUNT];  // stored results
    logic         sclk_rise, sclk_fall, pen_rise, aux_rise, start_req;
    logic [7:0]   status_byte;

    // edges of synchronous inputs
    assign sclk_rise = spi_sclk & ~sclk_q & ~spi_cs_n;
    assign sclk_fall = ~spi_sclk & sclk_q & ~spi_cs_n;
    assign pen_rise  = pen_touch & ~pen_q;
    assign aux_rise  = aux_sync & ~aux_q;

    // status byte shown to the host
    always_comb begin
        status_byte = 8'h00;
        status_byte[`TSC_ST_PEN_BIT]   = pen_flag_q;
        status_byte[`TSC_ST_DATA_BIT]  = data_rdy_q;
        status_byte[`TSC_ST_BUSY_BIT]  = (acq_q != ACQ_IDLE);
        status_byte[`TSC_ST_READY_BIT] = por_done_q;
    end

    // next channel, skipping what the panel setup does not offer
    function automatic logic [2:0] next_chan(input logic [2:0] ch,
                                             input tsc_cfg_s c);
        logic [2:0] n;
        n = ch + 3'h1;
        if (c.five_wire && (n == `TSC_CH_Z1)) begin
            n = `TSC_CH_AUX;
        end
        if ((n == `TSC_CH_AUX) && (c.five_wire || c.aux_trig)) begin
            n = `TSC_CH_END;
        end
        return n;
    endfunction

    // serial slave, configuration, flags and interrupt
    always_comb begin
        por_cnt_d  = por_cnt_q;
        por_done_d = por_done_q;
        sclk_d     = spi_sclk;
        pen_d      = pen_touch;
        aux_d      = aux_sync;
        bit_cnt_d  = bit_cnt_q;
        rx_d       = rx_q;
        cmd_d      = cmd_q;
        tx_d       = tx_q;
        oe_d       = ~spi_cs_n;
        cfg_d      = cfg_q;
        pen_flag_d = pen_flag_q;
        data_rdy_d = data_rdy_q;
        swrst_d    = 1'b0;
        conv_cmd_d = 1'b0;
        // power-up delay before the interrupt line is released
        if (!por_done_q) begin
            if (por_cnt_q == 17'(POR_CYCLES - 1)) begin
                por_done_d = 1'b1;
            end else begin
                por_cnt_d = por_cnt_q + 17'h1;
            end
        end
        // frame framing by chip select
        if (spi_cs_n) begin
            bit_cnt_d = 6'h00;
        end else if (sclk_rise && por_done_q) begin
            // sample on rising serial clock
            rx_d = {rx_q[6:0], spi_mosi};
            if (bit_cnt_q != 6'h3f) begin
                bit_cnt_d = bit_cnt_q + 6'h01;
            end
            if (bit_cnt_q == `TSC_CMD_BITS - 6'h01) begin
                cmd_d = {rx_q[6:0], spi_mosi};
                if (cmd_d[7:4] == `TSC_OP_SWRESET) begin
                    swrst_d = 1'b1;
                end
                if (cmd_d[7:4] == `TSC_OP_CONVERT) begin
                    conv_cmd_d = 1'b1;
                end
            end
            if ((bit_cnt_q == `TSC_CFG_BITS - 6'h01) &&
                (cmd_q[7:4] == `TSC_OP_WRCFG)) begin
                cfg_d = tsc_cfg_s'({rx_q[4:0], spi_mosi});
            end
        end else if (sclk_fall) begin
            // present data on falling serial clock
            if (bit_cnt_q == `TSC_CMD_BITS) begin
                case (cmd_q[7:4])
                    `TSC_OP_RDSTAT: begin
                        tx_d = {status_byte, 8'h00};
                        pen_flag_d = 1'b0;
                    end
                    `TSC_OP_RDCHAN: begin
                        tx_d = {1'b0, cmd_q[2:0],
                                (cmd_q[2:0] < `TSC_CH_END) ?
                                res_q[cmd_q[2:0]] : 12'h000};
                        data_rdy_d = 1'b0;
                    end
                    default: begin
                        tx_d = 16'h0000;
                    end
                endcase
            end else begin
                tx_d = {tx_q[14:0], 1'b0};
            end
        end
        // new events win over a clear in the same cycle
        if (pen_rise && por_done_q && (cfg_q.mode != TSC_MANUAL)) begin
            pen_flag_d = 1'b1;
        end
        if (seq_done) begin
            data_rdy_d = 1'b1;
        end
    end

    // interrupt pulled low until power-up ends, then on pending cause;
    // the next power-up state is used so the line lets go on the very
    // edge that completes the count, keeping the release inside 1 ms
    assign irq_oe_d = ~por_done_d | pen_flag_d | data_rdy_d;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            por_cnt_q  <= 17'h00000;
            por_done_q <= 1'b0;
            sclk_q     <= 1'b0;
            pen_q      <= 1'b0;
            aux_q      <= 1'b0;
            bit_cnt_q  <= 6'h00;
            rx_q       <= 8'h00;
            cmd_q      <= 8'h00;
            tx_q       <= 16'h0000;
            oe_q       <= 1'b0;
            cfg_q      <= tsc_cfg_s'(6'h00);
            pen_flag_q <= 1'b0;
            data_rdy_q <= 1'b0;
            irq_oe_q   <= 1'b1;
            swrst_q    <= 1'b0;
            conv_cmd_q <= 1'b0;
        end else if (swrst_q) begin
            // serial reset: pin reset state, but bit count kept and input samples and output enable taken from the pins
            por_cnt_q  <= 17'h00000;
            por_done_q <= 1'b0;
            sclk_q     <= spi_sclk;
            pen_q      <= pen_touch;
            aux_q      <= aux_sync;
            bit_cnt_q  <= bit_cnt_q;
            rx_q       <= 8'h00;
            cmd_q      <= 8'h00;
            tx_q       <= 16'h0000;
            oe_q       <= ~spi_cs_n;
            cfg_q      <= tsc_cfg_s'(6'h00);
            pen_flag_q <= 1'b0;
            data_rdy_q <= 1'b0;
            irq_oe_q   <= 1'b1;
            swrst_q    <= 1'b0;
            conv_cmd_q <= 1'b0;
        end else begin
            por_cnt_q  <= por_cnt_d;
            por_done_q <= por_done_d;
            sclk_q     <= sclk_d;
            pen_q      <= pen_d;
            aux_q      <= aux_d;
            bit_cnt_q  <= bit_cnt_d;
            rx_q       <= rx_d;
            cmd_q      <= cmd_d;
            tx_q       <= tx_d;
            oe_q       <= oe_d;
            cfg_q      <= cfg_d;
            pen_flag_q <= pen_flag_d;
            data_rdy_q <= data_rdy_d;
            irq_oe_q   <= irq_oe_d;
            swrst_q    <= swrst_d;
            conv_cmd_q <= conv_cmd_d;
        end
    end

    // acquisition triggers: pen, aux sync edge or manual command
    assign start_req = por_done_q &&
        (((cfg_q.mode == TSC_PENTRIG) && pen_rise) ||
         (cfg_q.aux_trig && !cfg_q.five_wire && aux_rise) ||
         conv_cmd_q);
    assign seq_done = (acq_q == ACQ_WAIT) && adc_done &&
                      (next_chan(chan_q, cfg_q) == `TSC_CH_END);

    // acquisition sequencer
    always_comb begin
        acq_d       = acq_q;
        chan_d      = chan_q;
        req_d.start = 1'b0;
        req_d.chan  = chan_q;
        case (acq_q)
            ACQ_IDLE: begin
                if (start_req) begin
                    chan_d = `TSC_CH_X;
                    acq_d  = ACQ_START;
                end
            end
            ACQ_START: begin
                // one-cycle start for the current channel
                req_d.start = 1'b1;
                req_d.chan  = chan_q;
                acq_d       = ACQ_WAIT;
            end
            ACQ_WAIT: begin
                if (adc_done) begin
                    chan_d = next_chan(chan_q, cfg_q);
                    acq_d  = (chan_d == `TSC_CH_END) ? ACQ_IDLE : ACQ_START;
                end
            end
            default: begin
                acq_d = ACQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acq_q  <= ACQ_IDLE;
            chan_q <= `TSC_CH_X;
            req_q  <= tsc_adc_req_s'(4'h0);
            for (int i = 0; i < `TSC_CH_COUNT; i++) begin
                res_q[i] <= 12'h000;
            end
        end else if (swrst_q) begin
            acq_q  <= ACQ_IDLE;
            chan_q <= `TSC_CH_X;
            req_q  <= tsc_adc_req_s'(4'h0);
        end else begin
            acq_q  <= acq_d;
            chan_q <= chan_d;
            req_q  <= req_d;
            // store each 12-bit result, aux included
            if ((acq_q == ACQ_WAIT) && adc_done) begin
                res_q[chan_q] <= adc_result;
            end
        end
    end

    // pin outputs straight from flip-flops
    assign spi_miso           = tx_q[15];
    assign spi_miso_oe        = oe_q;
    assign interrupt_out_n    = 1'b0 & irq_oe_q;
    assign interrupt_out_n_oe = irq_oe_q;
    assign adc_req            = req_q;
    assign cfg_out            = cfg_q;
endmodule
`default_nettype wire

// ---- hdl/tsc_map.svh ----
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
// clock and power-up timing
`define TSC_CLK_MHZ        125
`define TSC_POR_TIME_US    1000
`define TSC_POR_CYCLES     (`TSC_POR_TIME_US * `TSC_CLK_MHZ)
// serial command opcodes, upper nibble of the command byte
`define TSC_OP_WRCFG       4'h0
`define TSC_OP_RDSTAT      4'h1
`define TSC_OP_RDCHAN      4'h2
`define TSC_OP_SWRESET     4'h3
`define TSC_OP_CONVERT     4'h4
// serial frame bit counts
`define TSC_CMD_BITS       6'h08
`define TSC_CFG_BITS       6'h10
// configuration byte field positions
`define TSC_CFG_MODE_LSB   0
`define TSC_CFG_FIVE_BIT   2
`define TSC_CFG_AUXT_BIT   3
`define TSC_CFG_RSEL_LSB   4
// status byte bit positions
`define TSC_ST_PEN_BIT     0
`define TSC_ST_DATA_BIT    1
`define TSC_ST_BUSY_BIT    2
`define TSC_ST_READY_BIT   3
// converter channel codes
`define TSC_CH_X           3'h0
`define TSC_CH_Y           3'h1
`define TSC_CH_Z1          3'h2
`define TSC_CH_Z2          3'h3
`define TSC_CH_AUX         3'h4
`define TSC_CH_END         3'h5
`define TSC_CH_COUNT       5
`endif

// ---- hdl/tsc_pkg.sv ----
package tsc_pkg;
    // operating modes
    typedef enum logic [1:0] {
        TSC_MANUAL,
        TSC_PENDET,
        TSC_PENTRIG,
        TSC_RSVD
    } tsc_mode_e;

    // configuration written by the host
    typedef struct packed {
        logic [1:0] rsel;      // pen detect resistor choice
        logic       aux_trig;  // aux pin is acquisition trigger when five_wire is clear
        logic       five_wire; // five-wire panel attached
        tsc_mode_e  mode;      // operating mode
    } tsc_cfg_s;

    // converter request towards the analog front end
    typedef struct packed {
        logic       start;     // one-cycle conversion start
        logic [2:0] chan;      // channel to convert
    } tsc_adc_req_s;
endpackage

// ---- sim/tsc_host_ctrl_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// checker on the host-side ports of the controller
module tsc_host_ctrl_props
    import tsc_pkg::*;
#(parameter int unsigned POR_CYCLES = 20)
(
    input wire logic         mclk,
    input wire logic         reset_n,
    input wire logic         hard_reset_in_n,
    input wire logic         spi_cs_n,
    input wire logic         spi_miso_oe,
    input wire logic         interrupt_out_n,
    input wire logic         interrupt_out_n_oe,
    input wire logic         pen_touch,
    input wire tsc_adc_req_s adc_req,
    input wire tsc_cfg_s     cfg_out
);
    // one clock domain, both reset sources disable
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n || !hard_reset_in_n);

    por_hold_a: assert property ($rose(reset_n && hard_reset_in_n)
        |-> interrupt_out_n_oe [*8]) else $error("irq not held in power-up");
    rst_clean_a: assert property (
        $rose(reset_n && hard_reset_in_n)
        |-> cfg_out == '0 && !adc_req.start) else $error("reset left state");
    irq_drain_a: assert property (!interrupt_out_n)
        else $error("open-drain data not low");
    start_pulse_a: assert property (
        adc_req.start |=> !adc_req.start)
        else $error("start longer than one cycle");
    chan_legal_a: assert property (
        adc_req.start |-> adc_req.chan <= 3'h4)
        else $error("illegal channel");
    five_pos_a: assert property (
        adc_req.start && cfg_out.five_wire
        |-> adc_req.chan <= 3'h1) else $error("pressure on five-wire");
    aux_skip_a: assert property (adc_req.start && cfg_out.aux_trig
        |-> adc_req.chan != 3'h4) else $error("aux converted as trigger");
    miso_on_a: assert property ($fell(spi_cs_n) |=> spi_miso_oe)
        else $error("miso not driven when selected");
    miso_off_a: assert property (spi_cs_n [*2] |-> !spi_miso_oe)
        else $error("miso driven when idle");
    pen_irq_a: assert property ($rose(pen_touch)
        && cfg_out.mode == TSC_PENDET |-> ##[1:6] interrupt_out_n_oe)
        else $error("no irq on pen");
    irq_hold_a: assert property (interrupt_out_n_oe && spi_cs_n
        && cfg_out != '0 |=> interrupt_out_n_oe)
        else $error("irq dropped without service");
    // main scenarios reached
    cover property ($rose(interrupt_out_n_oe));
    cover property (adc_req.start && adc_req.chan == 3'h4);
    cover property ($fell(interrupt_out_n_oe) && !spi_cs_n);
endmodule
bind tsc_host_ctrl tsc_host_ctrl_props #(.POR_CYCLES(POR_CYCLES)) u_props (
    .mclk(mclk), .reset_n(reset_n), .hard_reset_in_n(hard_reset_in_n),
    .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
    .interrupt_out_n(interrupt_out_n), .pen_touch(pen_touch),
    .interrupt_out_n_oe(interrupt_out_n_oe), .adc_req(adc_req),
    .cfg_out(cfg_out)
);
`default_nettype wire

// ---- sim/tsc_spi_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// host processor as serial master, mode 0
module tsc_spi_host #(parameter int HALF = 6)
(
    input  wire logic mclk,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe,
    output var logic  spi_cs_n,
    output var logic  spi_sclk,
    output var logic  spi_mosi
);
    // idle: deselected, clock parked low
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    // one frame of 24 bits, or the command byte alone
    task automatic frame(input logic [23:0] tx, input logic short_f,
                         output logic [15:0] rx);
        int n;
        n = short_f ? 8 : 24;
        rx = 16'h0000;
        @(posedge mclk);
        spi_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_mosi <= tx[23-i];
            repeat (HALF) @(posedge mclk);
            spi_sclk <= 1'b1;
            repeat (HALF) @(posedge mclk);
            // undriven line reads as inverse of the last bit
            if (i >= 8) rx = {rx[14:0], spi_miso_oe ? spi_miso : ~rx[0]};
            spi_sclk <= 1'b0;
        end
        repeat (HALF) @(posedge mclk);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (HALF) @(posedge mclk);
        #1;
    endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tsc_pkg::*;
    localparam int POR = 20;             // short power-up count
    logic         mclk = 1'b0;           // system clock
    logic         reset_n = 1'b0;        // system reset
    logic         hard_reset_in_n = 1'b1; // reset pin, pulled high
    logic         pen_touch = 1'b0;      // pen comparator
    logic         aux_sync = 1'b0;       // aux trigger
    logic         adc_done = 1'b0;       // front end finished
    logic [11:0]  adc_result = 12'h000;  // front end result
    logic         cs_n, sclk, mosi, miso, miso_oe; // serial bus
    logic         irq_d, irq_oe, irq_line; // open-drain interrupt
    tsc_adc_req_s adc_req;               // converter request
    tsc_cfg_s     cfg_out;               // live configuration
    logic [15:0]  seq_v = 16'h0000;      // channels, 3 bits each
    int           seq_n = 0;             // conversions started
    logic         seq_clr = 1'b0;        // clears the channel log
    int           adc_wait = 0;          // cycles to answer
    int           fail_count = 0;
    int           cmp_count = 0;
    logic [15:0]  rx;                    // last serial answer

    assign irq_line = irq_oe ? irq_d : 1'b1; // pull-up
    tsc_host_ctrl #(.POR_CYCLES(POR)) dut (
        .mclk(mclk), .reset_n(reset_n), .hard_reset_in_n(hard_reset_in_n),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(miso_oe), .interrupt_out_n(irq_d),
        .interrupt_out_n_oe(irq_oe), .pen_touch(pen_touch),
        .aux_sync(aux_sync), .adc_done(adc_done), .adc_result(adc_result),
        .adc_req(adc_req), .cfg_out(cfg_out));
    tsc_spi_host host (.mclk(mclk), .spi_miso(miso), .spi_miso_oe(miso_oe),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi));
    always #4 mclk = ~mclk;
    // front end: answers each start five cycles later
    always @(posedge mclk) begin
        adc_done <= adc_wait == 1 && adc_req.start !== 1'b1;
        adc_wait <= adc_req.start === 1'b1 ? 5 : adc_wait - (adc_wait > 0);
        if (seq_clr) begin
            // log restarted by the scenario
            seq_v <= 16'h0000;
            seq_n <= 0;
        end else if (adc_req.start === 1'b1) begin
            seq_v <= {seq_v[12:0], adc_req.chan};
            seq_n <= seq_n + 1;
        end
        if (adc_req.start === 1'b1) begin
            adc_result <= {9'h150, adc_req.chan};
        end
    end
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // line low during power-up, released once the count runs out
    task automatic t_power_up;
        tick(1);
        check("irq in power-up", 16'h0, irq_line);
        tick(POR + 3);
        check("irq after power-up", 16'h1, irq_line);
    endtask
    // serial reset and pin reset both clear the configuration
    task automatic t_resets;
        host.frame(24'h003500, 1'b0, rx);
        check("cfg", 16'h35, cfg_out);
        host.frame(24'h300000, 1'b1, rx);
        check("cfg soft", 16'h0, cfg_out);
        check("irq soft", 16'h0, irq_line);
        tick(POR + 3);
        host.frame(24'h003500, 1'b0, rx);
        @(posedge mclk) hard_reset_in_n <= 1'b0;
        tick(3);
        check("cfg pin", 16'h0, cfg_out);
        check("irq pin", 16'h0, irq_line);
        @(posedge mclk) hard_reset_in_n <= 1'b1;
        tick(POR + 3);
        check("irq after pin", 16'h1, irq_line);
    endtask
    // touch in pen-detect mode: held until the status read
    task automatic t_pen;
        host.frame(24'h000100, 1'b0, rx);
        @(posedge mclk) pen_touch <= 1'b1;
        tick(100);
        check("irq held", 16'h0, irq_line);
        host.frame(24'h100000, 1'b0, rx);
        check("status", 16'h0900, rx);
        check("irq cleared", 16'h1, irq_line);
        @(posedge mclk) pen_touch <= 1'b0;
    endtask
    // one acquisition: channel order, interrupt, read-back
    task automatic acq(input logic [7:0] cfg, input int trig,
                       input logic [15:0] e_seq, input logic [15:0] e_n,
                       input logic [7:0] e_st, input logic [2:0] ch);
        host.frame({8'h00, cfg, 8'h00}, 1'b0, rx);
        @(posedge mclk) seq_clr <= 1'b1;
        @(posedge mclk) seq_clr <= 1'b0;
        if (trig == 0) host.frame(24'h400000, 1'b0, rx);
        @(posedge mclk) aux_sync <= trig == 1;
        pen_touch <= trig == 2;
        for (int i = 0; i < 900 && seq_n < e_n; i++) @(posedge mclk);
        tick(12);
        check("seq", e_seq, seq_v);
        check("count", e_n, seq_n[15:0]);
        check("irq data", 16'h0, irq_line);
        host.frame(24'h100000, 1'b0, rx);
        check("status", {e_st, 8'h00}, rx);
        host.frame({5'h04, ch, 16'h0000}, 1'b0, rx);
        check("channel", {1'b0, ch, 9'h150, ch}, rx);
        check("irq done", 16'h1, irq_line);
        @(posedge mclk) aux_sync <= 1'b0;
        pen_touch <= 1'b0;
    endtask
    task automatic t_four;
        acq(8'h00, 0, 16'h029c, 5, 8'h0a, 3'h4);
    endtask
    task automatic t_five;
        acq(8'h04, 0, 16'h0001, 2, 8'h0a, 3'h1);
    endtask
    task automatic t_aux_trig;
        acq(8'h08, 1, 16'h0053, 4, 8'h0a, 3'h3);
    endtask
    task automatic t_pen_trig;
        acq(8'h02, 2, 16'h029c, 5, 8'h0b, 3'h0);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        t_power_up;
        t_resets;
        t_pen;
        t_four;
        t_five;
        t_aux_trig;
        t_pen_trig;
        end_of_test;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        end_of_test;
    end
endmodule
`default_nettype wire
